// [rtl/blm_pin_mux.sv]
// Selector for one routed output pin
`timescale 1ns/10ps
`default_nettype none
`include "blm_regs.svh"
module blm_pin_mux (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [4:0] sel_i,
    input wire logic [7:0] flags_i,
    input wire logic irq_i,
    output logic pin_o
);
    blm_pkg::blm_pin_state_t s;
    blm_pkg::blm_pin_state_t ns;

    always_comb begin
        ns = s;
        unique case (sel_i)
            `BLM_SEL_SLOT_A: ns.pin = |flags_i[3:0];
            `BLM_SEL_SLOT_B: ns.pin = |flags_i[7:4];
            `BLM_SEL_ALL: ns.pin = |flags_i;
            `BLM_SEL_ALL_IRQ: ns.pin = (|flags_i) | irq_i;
            default: ns.pin = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= ns;
        end
    end

    assign pin_o = s.pin;

    // ======================================================================
    // Checks
    a_pin_slot_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        sel_i == `BLM_SEL_SLOT_A |=> pin_o == $past(|flags_i[3:0]))
        else $error("pin does not follow slot A flags");
    a_pin_with_irq: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        sel_i == `BLM_SEL_ALL_IRQ && irq_i |=> pin_o)
        else $error("pin misses interrupt term");
    a_pin_released: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        sel_i == `BLM_SEL_SLOT_B && flags_i[7:4] == 4'h0 |=> !pin_o)
        else $error("pin held with no flag set");
endmodule
`default_nettype wire

// [rtl/blm_tally.sv]
// Exceedance tally and sticky flag of one channel
`timescale 1ns/10ps
`default_nettype none
`include "blm_regs.svh"
module blm_tally (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic hit_i,
    input wire logic [1:0] limit_code_i,
    input wire logic clear_i,
    output logic flag_o,
    output logic set_o
);
    blm_pkg::blm_tally_state_t s;
    blm_pkg::blm_tally_state_t ns;
    logic [4:0] target;
    logic [4:0] bumped;

    // ======================================================================
    // Next state
    always_comb begin
        ns = s;
        set_o = 1'b0;
        bumped = s.tally + 5'h01;
        unique case (limit_code_i)
            `BLM_CODE_NEVER: target = 5'h00;
            `BLM_CODE_ONE: target = `BLM_LIMIT_ONE;
            `BLM_CODE_FOUR: target = `BLM_LIMIT_FOUR;
            default: target = `BLM_LIMIT_SIXTEEN;
        endcase
        if (clear_i) begin
            ns.flag = 1'b0;
        end
        // Restart after each set so every flag needs a fresh run of hits
        if (hit_i && limit_code_i != `BLM_CODE_NEVER) begin
            if (bumped >= target) begin
                ns.tally = 5'h00;
                ns.flag = 1'b1;
                set_o = 1'b1;
            end else begin
                ns.tally = bumped;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s <= '0;
        end else begin
            s <= ns;
        end
    end

    assign flag_o = s.flag;

    // ======================================================================
    // Checks
    a_code_zero_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        limit_code_i == `BLM_CODE_NEVER |-> !set_o)
        else $error("flag set with limit code zero");
    a_code_one_sets: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        hit_i && limit_code_i == `BLM_CODE_ONE |=> flag_o)
        else $error("single hit did not set flag");
    a_four_hits: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        set_o && limit_code_i == `BLM_CODE_FOUR && $stable(limit_code_i) |-> s.tally >= 5'h03)
        else $error("flag set before four hits");
    a_sixteen_hits: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        set_o && limit_code_i == 2'h3 && $stable(limit_code_i) |-> s.tally == 5'h0F)
        else $error("flag set before sixteen hits");
    a_flag_sticks: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        flag_o && !clear_i |=> flag_o)
        else $error("flag dropped without read");
endmodule
`default_nettype wire

// [rtl/blm_top.sv]
// Background light monitor: Avalon-MM registers, per-channel tallies and pin routing
//
// Operation
// - Slot A channel flags one to four sit in status bits 3 to 0.
// - Slot B channel flags one to four sit in status bits 7 to 4.
// - A set flag means its tally reached the limit; it stays until read.
// - Reading the status register clears the flags it returned.
// - Float-mode subtract-cycle results above the 14-bit slot threshold bump that channel's tally.
// - A 2-bit limit field in bits 15 to 14 selects the needed count.
// - Limit code zero never sets a flag; code one sets after one hit.
// - Limit code two needs four hits; code three needs sixteen.
// - Pin zero selector in bits 4 to 0; code 0x10 gives slot A OR.
// - Code 0x1A gives slot B OR; code 0x1B gives OR of all flags.
// - Code 0x1C gives OR of all flags together with the interrupt.
// - Pin one selector in bits 12 to 8 uses the same codes.
// - Compared value is raw conversion minus the channel's offset register.
// - Only subtract cycles, where the LED is masked, are compared.
// - Each channel of each slot has its own tally fed only by itself.
`timescale 1ns/10ps
`default_nettype none
`include "blm_regs.svh"
module blm_top (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic adc_valid_i,
    input wire logic adc_slot_i,
    input wire logic [1:0] adc_channel_i,
    input wire logic [13:0] adc_raw_i,
    input wire logic adc_subtract_i,
    input wire logic float_mode_i,
    output logic irq_o,
    output logic pin_zero_o,
    output logic pin_one_o
);
    // ======================================================================
    // Reset release
    logic [1:0] rst_sync;
    logic rst_n;

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // ======================================================================
    // State
    blm_pkg::blm_top_state_t s;
    blm_pkg::blm_top_state_t ns;
    logic [7:0] flags;
    logic [7:0] flag_set;
    logic [2:0] chan;
    logic [13:0] ofs_sel;
    logic [13:0] thr_sel;
    logic [14:0] diff;
    logic exceed;
    logic bus_req;
    logic [31:0] rd_mux;
    logic [7:0] wr_mask;
    logic [15:0] ofs_new;

    // Byte-lane merge for the 16-bit registers
    function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                               input logic [15:0] new_v,
                                               input logic [1:0] be);
        lane_merge = {be[1] ? new_v[15:8] : old_v[15:8],
                      be[0] ? new_v[7:0] : old_v[7:0]};
    endfunction

    // ======================================================================
    // Comparison against the slot threshold
    always_comb begin
        chan = {adc_slot_i, adc_channel_i};
        ofs_sel = s.adc_ofs[chan];
        thr_sel = adc_slot_i ? s.lim_b[`BLM_THR_MSB:0] : s.lim_a[`BLM_THR_MSB:0];
        diff = {1'b0, adc_raw_i} - {1'b0, ofs_sel};
        // A result below the offset is a negative value and never exceeds
        exceed = !diff[14] && (diff[13:0] > thr_sel);
    end

    // ======================================================================
    // Register read view
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (avs_address_i == `BLM_IDX_STATUS) begin
            rd_mux[7:0] = flags;
        end else if (avs_address_i == `BLM_IDX_PIN_CFG) begin
            rd_mux[15:0] = s.pin_cfg;
        end else if (avs_address_i == `BLM_IDX_LIMIT_A) begin
            rd_mux[15:0] = s.lim_a;
        end else if (avs_address_i == `BLM_IDX_LIMIT_B) begin
            rd_mux[15:0] = s.lim_b;
        end else if (avs_address_i == `BLM_IDX_IRQ_STAT) begin
            rd_mux[7:0] = s.irq_stat;
        end else if (avs_address_i == `BLM_IDX_IRQ_MASK) begin
            rd_mux[7:0] = s.irq_mask;
        end
        for (int i = 0; i < 4; i++) begin
            if (avs_address_i == `BLM_IDX_OFS_A + 6'(i)) begin
                rd_mux[13:0] = s.adc_ofs[i];
            end
            if (avs_address_i == `BLM_IDX_OFS_B + 6'(i)) begin
                rd_mux[13:0] = s.adc_ofs[i + 4];
            end
        end
    end

    // ======================================================================
    // Next state
    assign bus_req = avs_read_i || avs_write_i;

    always_comb begin
        ns = s;
        wr_mask = 8'h00;
        ofs_new = 16'h0000;
        ns.irq = |(s.irq_stat & s.irq_mask);
        ns.hit = 8'h00;
        if (adc_valid_i && float_mode_i && adc_subtract_i && exceed) begin
            ns.hit[chan] = 1'b1;
        end
        unique case (s.bus)
            blm_pkg::BLM_BUS_IDLE: begin
                ns.rd_flags = 8'h00;
                ns.wait_req = 1'b1;
                if (bus_req) begin
                    ns.bus = blm_pkg::BLM_BUS_ACK;
                    ns.wait_req = 1'b0;
                    ns.rdata = avs_read_i ? rd_mux : s.rdata;
                    // Only bits actually returned are cleared, so a flag set in
                    // the gap before the clearing edge is not lost
                    if (avs_read_i && avs_address_i == `BLM_IDX_STATUS) begin
                        ns.rd_flags = flags;
                    end
                end
            end
            blm_pkg::BLM_BUS_ACK: begin
                ns.bus = blm_pkg::BLM_BUS_IDLE;
                ns.wait_req = 1'b1;
                ns.rd_flags = 8'h00;
                if (avs_write_i) begin
                    if (avs_address_i == `BLM_IDX_PIN_CFG) begin
                        ns.pin_cfg = lane_merge(s.pin_cfg, avs_writedata_i[15:0],
                                                avs_byteenable_i[1:0]) & `BLM_PIN_CFG_MASK;
                    end
                    if (avs_address_i == `BLM_IDX_LIMIT_A) begin
                        ns.lim_a = lane_merge(s.lim_a, avs_writedata_i[15:0],
                                              avs_byteenable_i[1:0]);
                    end
                    if (avs_address_i == `BLM_IDX_LIMIT_B) begin
                        ns.lim_b = lane_merge(s.lim_b, avs_writedata_i[15:0],
                                              avs_byteenable_i[1:0]);
                    end
                    if (avs_address_i == `BLM_IDX_IRQ_MASK && avs_byteenable_i[0]) begin
                        ns.irq_mask = avs_writedata_i[7:0];
                    end
                    if (avs_address_i == `BLM_IDX_IRQ_STAT && avs_byteenable_i[0]) begin
                        wr_mask = avs_writedata_i[7:0];
                    end
                    for (int i = 0; i < 4; i++) begin
                        if (avs_address_i == `BLM_IDX_OFS_A + 6'(i)) begin
                            ofs_new = lane_merge({2'h0, s.adc_ofs[i]},
                                avs_writedata_i[15:0], avs_byteenable_i[1:0]);
                            ns.adc_ofs[i] = ofs_new[13:0];
                        end
                        if (avs_address_i == `BLM_IDX_OFS_B + 6'(i)) begin
                            ofs_new = lane_merge({2'h0, s.adc_ofs[i + 4]},
                                avs_writedata_i[15:0], avs_byteenable_i[1:0]);
                            ns.adc_ofs[i + 4] = ofs_new[13:0];
                        end
                    end
                end
            end
        endcase
        // A new event wins over a write-one clear in the same cycle
        ns.irq_stat = (s.irq_stat & ~wr_mask) | flag_set;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{bus: blm_pkg::BLM_BUS_IDLE, wait_req: 1'b1, rdata: 32'h0000_0000,
                   rd_flags: `BLM_RST_FLAGS, pin_cfg: `BLM_RST_REG16,
                   lim_a: `BLM_RST_REG16, lim_b: `BLM_RST_REG16,
                   adc_ofs: {8{`BLM_RST_OFS}}, hit: 8'h00,
                   irq_stat: `BLM_RST_FLAGS, irq_mask: `BLM_RST_FLAGS, irq: 1'b0};
        end else begin
            s <= ns;
        end
    end

    assign avs_readdata_o = s.rdata;
    assign avs_waitrequest_o = s.wait_req;
    assign irq_o = s.irq;

    // ======================================================================
    // Channel tallies, slot A in the low four, slot B in the high four
    for (genvar g = 0; g < 8; g++) begin : g_chan
        blm_tally u_tally (
            .clk_sys_i(clk_sys_i),
            .rst_n_i(rst_n),
            .hit_i(s.hit[g]),
            .limit_code_i(g < 4 ? s.lim_a[`BLM_CNT_MSB:`BLM_CNT_LSB]
                                : s.lim_b[`BLM_CNT_MSB:`BLM_CNT_LSB]),
            .clear_i(s.rd_flags[g]),
            .flag_o(flags[g]),
            .set_o(flag_set[g])
        );
    end

    // ======================================================================
    // Routed pins
    blm_pin_mux u_pin_zero (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n),
        .sel_i(s.pin_cfg[`BLM_PIN0_MSB:`BLM_PIN0_LSB]),
        .flags_i(flags),
        .irq_i(s.irq),
        .pin_o(pin_zero_o)
    );

    blm_pin_mux u_pin_one (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n),
        .sel_i(s.pin_cfg[`BLM_PIN1_MSB:`BLM_PIN1_LSB]),
        .flags_i(flags),
        .irq_i(s.irq),
        .pin_o(pin_one_o)
    );

    // ======================================================================
    // Checks
    sequence req_taken;
        s.bus == blm_pkg::BLM_BUS_IDLE && bus_req;
    endsequence

    sequence ack_pulse;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence

    a_bus_one_wait: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        req_taken |=> ack_pulse)
        else $error("waitrequest not low for exactly one cycle");

    a_read_clears: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        req_taken ##0 (avs_read_i && avs_address_i == `BLM_IDX_STATUS && flag_set == 8'h00)
        ##1 flag_set == 8'h00 |=> (flags & $past(s.rd_flags)) == 8'h00)
        else $error("status read did not clear flags");

    a_status_view: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        req_taken ##0 (avs_read_i && avs_address_i == `BLM_IDX_STATUS)
        |=> avs_readdata_o[7:0] == $past(flags) && avs_readdata_o[31:8] == 24'h000000)
        else $error("status read returns wrong layout");

    a_hit_needs_sub: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        s.hit != 8'h00 |-> $past(adc_subtract_i && float_mode_i && adc_valid_i))
        else $error("tally bumped outside a subtract cycle");

    a_offset_compare: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        adc_valid_i && float_mode_i && adc_subtract_i
        && {2'h0, adc_raw_i} > {2'h0, ofs_sel} + {2'h0, thr_sel}
        |=> s.hit == 8'h01 << $past(chan))
        else $error("exceeding result not counted");

    a_irq_level: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
        (s.irq_stat & s.irq_mask) != 8'h00 |=> irq_o)
        else $error("interrupt missing for unmasked status");
endmodule
`default_nettype wire

// [shared/blm_pkg.sv]
// Types of the background light monitor
`default_nettype none
package blm_pkg;

    typedef enum logic [1:0] {
        BLM_BUS_IDLE = 2'b01,
        BLM_BUS_ACK = 2'b10
    } blm_bus_t;

    typedef struct packed {
        blm_bus_t bus;
        logic wait_req;
        logic [31:0] rdata;
        logic [7:0] rd_flags;
        logic [15:0] pin_cfg;
        logic [15:0] lim_a;
        logic [15:0] lim_b;
        logic [7:0][13:0] adc_ofs;
        logic [7:0] hit;
        logic [7:0] irq_stat;
        logic [7:0] irq_mask;
        logic irq;
    } blm_top_state_t;

    typedef struct packed {
        logic [4:0] tally;
        logic flag;
    } blm_tally_state_t;

    typedef struct packed {
        logic pin;
    } blm_pin_state_t;

endpackage
`default_nettype wire

// [shared/blm_regs.svh]
// Register indices, field positions, reset values and codes of the background light monitor
`ifndef BLM_REGS_SVH
`define BLM_REGS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
`define BLM_IDX_STATUS 6'h04
`define BLM_IDX_PIN_CFG 6'h0B
`define BLM_IDX_LIMIT_A 6'h16
`define BLM_IDX_OFS_A 6'h18
`define BLM_IDX_LIMIT_B 6'h1C
`define BLM_IDX_OFS_B 6'h1E
`define BLM_IDX_IRQ_STAT 6'h30
`define BLM_IDX_IRQ_MASK 6'h31

// ==========================================================================
// Field positions
`define BLM_THR_MSB 13
`define BLM_CNT_MSB 15
`define BLM_CNT_LSB 14
`define BLM_PIN0_MSB 4
`define BLM_PIN0_LSB 0
`define BLM_PIN1_MSB 12
`define BLM_PIN1_LSB 8
`define BLM_PIN_CFG_MASK 16'h1F1F

// ==========================================================================
// Reset values
`define BLM_RST_REG16 16'h0000
`define BLM_RST_OFS 14'h0000
`define BLM_RST_FLAGS 8'h00

// ==========================================================================
// Tally limit codes and their counts
`define BLM_CODE_NEVER 2'h0
`define BLM_CODE_ONE 2'h1
`define BLM_CODE_FOUR 2'h2
`define BLM_LIMIT_ONE 5'h01
`define BLM_LIMIT_FOUR 5'h04
`define BLM_LIMIT_SIXTEEN 5'h10

// ==========================================================================
// Pin selector codes
`define BLM_SEL_SLOT_A 5'h10
`define BLM_SEL_SLOT_B 5'h1A
`define BLM_SEL_ALL 5'h1B
`define BLM_SEL_ALL_IRQ 5'h1C

`endif

// [tb/blm_host_model.sv]
// Host processor model: Avalon-MM master that polls and configures the monitor
`timescale 1ns/10ps
`default_nettype none
module blm_host_model (
    input wire logic clk_sys_i,
    input wire logic go_i,
    input wire logic rd_i,
    input wire logic [5:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic avs_waitrequest_i,
    input wire logic [31:0] avs_readdata_i,
    output logic [5:0] avs_address_o,
    output logic avs_read_o,
    output logic avs_write_o,
    output logic [31:0] avs_writedata_o,
    output logic done_o,
    output logic [31:0] rdata_o
);
    // ====================================
    // Bus master
    initial begin
        avs_address_o = 6'h00;
        avs_read_o = 1'b0;
        avs_write_o = 1'b0;
        avs_writedata_o = 32'h00000000;
        done_o = 1'b0;
        rdata_o = 32'h00000000;
    end

    // Request stands until waitrequest is sampled low; polls on demand
    always @(posedge clk_sys_i) begin
        done_o <= 1'b0;
        if ((avs_read_o || avs_write_o) && !avs_waitrequest_i) begin
            rdata_o <= avs_readdata_i;
            avs_read_o <= 1'b0;
            avs_write_o <= 1'b0;
            // Released lines must not keep showing the last value
            avs_address_o <= ~avs_address_o;
            avs_writedata_o <= ~avs_writedata_o;
            done_o <= 1'b1;
        end else if (go_i && !avs_read_o && !avs_write_o) begin
            avs_read_o <= rd_i;
            avs_write_o <= !rd_i;
            avs_address_o <= addr_i;
            avs_writedata_o <= {16'h0000, wdata_i};
        end
    end
endmodule
`default_nettype wire

// [tb/test_background_light_monitor.sv]
// Self-checking testbench of the background light monitor
`timescale 1ns/10ps
`default_nettype none
module test_background_light_monitor;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [5:0] adr;
    logic rd, wr, wt, done, go, h_rd, irq, p0, p1;
    logic [31:0] wd, rdat, rdata;
    logic [5:0] h_addr;
    logic [15:0] h_wdata;
    logic adc_valid, adc_slot, adc_sub, flt;
    logic [1:0] adc_ch;
    logic [13:0] adc_raw;
    int fails = 0;
    int num_checks = 0;
    integer seed = 32'h81DA;
    logic [4:0] codes [5] = '{5'h10, 5'h1A, 5'h1B, 5'h1C, 5'h00};

    always #50 clk_sys_i = ~clk_sys_i;

    blm_top i_dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .adc_valid_i(adc_valid),
        .adc_slot_i(adc_slot), .adc_channel_i(adc_ch), .adc_raw_i(adc_raw),
        .adc_subtract_i(adc_sub), .float_mode_i(flt), .irq_o(irq), .pin_zero_o(p0),
        .pin_one_o(p1));

    blm_host_model i_host (.clk_sys_i(clk_sys_i), .go_i(go), .rd_i(h_rd), .addr_i(h_addr),
        .wdata_i(h_wdata), .avs_waitrequest_i(wt), .avs_readdata_i(rdat),
        .avs_address_o(adr), .avs_read_o(rd), .avs_write_o(wr), .avs_writedata_o(wd),
        .done_o(done), .rdata_o(rdata));

    // ====================================
    // Helpers
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic bus(input logic r, input logic [5:0] a, input logic [15:0] d);
        int n = 0;
        @(posedge clk_sys_i);
        {go, h_rd, h_addr, h_wdata} <= {1'b1, r, a, d};
        @(posedge clk_sys_i);
        go <= 1'b0;
        while (done !== 1'b1) begin
            @(posedge clk_sys_i);
            n++;
            if (n > 50) begin
                fails++;
                close_out();
            end
        end
    endtask

    task automatic samp(input logic s, input logic [1:0] c, input logic [13:0] r,
                        input logic sb, input logic f);
        @(posedge clk_sys_i);
        {adc_valid, adc_slot, adc_ch, adc_raw, adc_sub, flt} <= {1'b1, s, c, r, sb, f};
        @(posedge clk_sys_i);
        // Qualifiers wander while valid is low; the design must ignore them
        {adc_valid, adc_slot, adc_ch, adc_raw, adc_sub, flt} <= {1'b0, 19'($random(seed))};
    endtask

    function automatic int lim_n(input logic [1:0] c);
        return (c == 2'h1) ? 1 : (c == 2'h2) ? 4 : 16;
    endfunction

    function automatic logic pin_exp(input logic [4:0] c, input logic a, input logic b,
                                     input logic q);
        case (c)
            5'h10: return a;
            5'h1A: return b;
            5'h1B: return a | b;
            5'h1C: return a | b | q;
            default: return 1'b0;
        endcase
    endfunction

    initial begin
        repeat (100000) @(posedge clk_sys_i);
        fails++;
        close_out();
    end

    // ====================================
    // Main sequence
    initial begin
        logic s;
        logic [1:0] c, code;
        logic [13:0] thr, off;
        logic a, b;
        {go, h_rd, h_addr, h_wdata} = '0;
        {adc_valid, adc_slot, adc_ch, adc_raw, adc_sub, flt} = '0;
        repeat (6) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        foreach (codes[j]) begin
            bus(1'b1, (j == 0) ? 6'h04 : (j == 1) ? 6'h0B : (j == 2) ? 6'h16 : 6'h1C, 16'h0);
            chk("reset_value", rdata, 32'h0);
        end
        bus(1'b0, 6'h3F, 16'hFFFF);
        bus(1'b1, 6'h3F, 16'h0);
        chk("unmapped", rdata, 32'h0);
        bus(1'b0, 6'h0B, 16'hFFFF);
        bus(1'b1, 6'h0B, 16'h0);
        chk("pin_select", rdata, 32'h1F1F);
        // Every channel of both slots under every limit code, with decoy samples
        for (int i = 0; i < 32; i++) begin
            {code, s, c} = i[4:0];
            thr = 14'($random(seed) & 32'h0FFF);
            off = 14'($random(seed) & 32'h0FFF) | 14'h0001;
            bus(1'b0, s ? 6'h1C : 6'h16, {code, thr});
            bus(1'b0, (s ? 6'h1E : 6'h18) + {4'h0, c}, {2'b00, off});
            samp(s, c, off + thr, 1'b1, 1'b1);
            samp(s, c, off - 14'h0001, 1'b1, 1'b1);
            samp(s, c, off + thr + 14'h0001, 1'b0, 1'b1);
            samp(s, c, off + thr + 14'h0001, 1'b1, 1'b0);
            for (int k = 1; k < lim_n(code); k++)
                samp(s, c, off + thr + 14'h0001 + 14'($random(seed) & 32'h0FFF), 1'b1, 1'b1);
            repeat (4) @(posedge clk_sys_i);
            bus(1'b1, 6'h04, 16'h0);
            chk("flags_early", rdata, 32'h0);
            samp(s, c, off + thr + 14'h0001, 1'b1, 1'b1);
            repeat (4) @(posedge clk_sys_i);
            bus(1'b1, 6'h04, 16'h0);
            chk("flags", rdata, (code == 2'h0) ? 32'h0 : {24'h0, 8'h01 << {s, c}});
            bus(1'b1, 6'h04, 16'h0);
            chk("flags_cleared", rdata, 32'h0);
        end
        // Pin routing for each selector code on both pins
        bus(1'b0, 6'h16, 16'h4100);
        bus(1'b0, 6'h1C, 16'h4100);
        bus(1'b0, 6'h18, 16'h0);
        bus(1'b0, 6'h1E, 16'h0);
        bus(1'b0, 6'h1A, 16'h0);
        bus(1'b0, 6'h30, 16'h00FF);
        bus(1'b0, 6'h31, 16'h0);
        for (int ph = 0; ph < 3; ph++) begin
            if (ph == 1)
                bus(1'b1, 6'h04, 16'h0);
            else
                samp(ph[1], 2'h0, 14'h0200, 1'b1, 1'b1);
            {a, b} = (ph == 0) ? 2'b10 : (ph == 1) ? 2'b00 : 2'b01;
            repeat (4) @(posedge clk_sys_i);
            for (int j = 0; j < 5; j++) begin
                bus(1'b0, 6'h0B, {3'b000, codes[(j + 1) % 5], 3'b000, codes[j]});
                repeat (3) @(posedge clk_sys_i);
                chk("pin_zero", {31'h0, p0}, {31'h0, pin_exp(codes[j], a, b, 1'b0)});
                chk("pin_one", {31'h0, p1}, {31'h0, pin_exp(codes[(j + 1) % 5], a, b, 1'b0)});
            end
        end
        // Interrupt: raised masked, unmasked, routed alone to a pin, then cleared
        bus(1'b1, 6'h04, 16'h0);
        bus(1'b0, 6'h30, 16'h00FF);
        samp(1'b0, 2'h2, 14'h0200, 1'b1, 1'b1);
        repeat (4) @(posedge clk_sys_i);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        bus(1'b1, 6'h30, 16'h0);
        chk("irq_status", rdata, 32'h04);
        bus(1'b0, 6'h31, 16'h0004);
        repeat (2) @(posedge clk_sys_i);
        chk("irq_raised", {31'h0, irq}, 32'h1);
        bus(1'b0, 6'h0B, 16'h1C10);
        bus(1'b1, 6'h04, 16'h0);
        repeat (3) @(posedge clk_sys_i);
        chk("pin_zero_irq", {31'h0, p0}, 32'h0);
        chk("pin_one_irq", {31'h0, p1}, 32'h1);
        bus(1'b0, 6'h30, 16'h0004);
        repeat (4) @(posedge clk_sys_i);
        chk("irq_cleared", {31'h0, irq}, 32'h0);
        chk("pin_one_idle", {31'h0, p1}, 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
